// File: src/baud_pkg.sv
// constants for the baud rate generator block: register map, fields, resets
// assumes an axi4-lite slave with 32-bit data, one register per aligned word
package baud_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_HIGH   = 8'h00;
  localparam logic [7:0] ADDR_LOW    = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_OPTION = 8'h14;
  // field positions in the high register
  localparam int BRK_IE_BIT  = 7;
  localparam int EDGE_IE_BIT = 6;
  localparam int HIGH_MSB    = 4;
  // control register bits
  localparam int RX_EN_BIT   = 0;
  localparam int TX_EN_BIT   = 1;
  // status bits
  localparam int ST_BRK_BIT  = 0;
  localparam int ST_EDGE_BIT = 1;
  // values after reset
  localparam logic [4:0] HIGH_RESET = 5'h00;
  localparam logic [7:0] LOW_RESET  = 8'h04;
  // oversampling ticks per bit
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'hF;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : baud_pkg

// File: src/baud_counter.sv
// modulo down-counter producing one oversampling tick per reload
// assumes divisor and run enable come from logic on the same clock
`timescale 1ns/1ps
module baud_counter (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        run,
  input  wire logic [12:0] divisor,
  // tick output
  output logic             tick
);
  logic [12:0] count_q;
  logic [12:0] count_d;
  logic        at_end;

  // reload at one, so a divisor n gives one tick every n clocks
  assign at_end  = (count_q <= 13'h0001);
  assign count_d = !run ? divisor : (at_end ? divisor : count_q - 13'h0001);

  // counter loads the divisor and tick is held low while stopped, so no toggling with a zero divisor
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q <= 13'h0000;
      tick    <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      tick    <= run && at_end;
    end
  end
endmodule : baud_counter

// File: src/baud_rate_gen.sv
// baud rate generator with divisor registers, interrupt enables and pin routing
// assumes an axi4-lite master and break / edge events from the serial core
`timescale 1ns/1ps
// Operation
// - nonzero divisor gives bit rate bus clock over sixteen times divisor
// - zero divisor stops the generator completely
// - 13-bit divisor: high bits 4:0 of high register, low bits 7:0 of low
// - high write is buffered; working divisor loads on low register write
// - low resets nonzero; generator idle until rx or tx enable first written one
// - high bit 7 enables break-detect interrupt from the break flag
// - high bit 6 enables receive-edge interrupt from the edge flag
// - position select routes channel two pins: zero port f, one port e
module baud_rate_gen (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // events from the serial core
  input  wire logic        break_event,
  input  wire logic        rx_edge_event,
  // generator outputs
  output logic             oversample_tick,
  output logic             bit_tick,
  output logic [12:0]      baud_divisor,
  // channel two pin routing
  input  wire logic        second_channel_tx_pin,
  output logic             second_channel_rx_pin,
  input  wire logic        port_f1_in,
  input  wire logic        port_e7_in,
  output logic             port_f0_out,
  output logic             port_f0_oe,
  output logic             port_e6_out,
  output logic             port_e6_oe,
  // interrupt
  output logic             irq
);
  // registers
  logic [7:0]  high_q;
  logic [4:0]  high_work_q;
  logic [7:0]  low_q;
  logic [1:0]  ctrl_q;
  logic        started_q;
  logic [1:0]  status_q;
  logic [1:0]  mask_q;
  logic        pos_sel_q;
  logic [3:0]  sub_q;
  logic        bit_tick_q;
  // pin synchronisers
  logic [1:0]  f1_sync_q;
  logic [1:0]  e7_sync_q;
  // axi state
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  // write channel capture: address and data taken in either order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  wire       aw_take  = s_axi_awvalid && s_axi_awready;
  wire       w_take   = s_axi_wvalid && s_axi_wready;
  wire       aw_have  = aw_held_q || aw_take;
  wire       w_have   = w_held_q || w_take;
  wire [7:0] wr_addr  = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb  = w_held_q ? w_strb_q : s_axi_wstrb;
  wire       wr_fire  = aw_have && w_have && !bvalid_q;
  wire       wr_lane0 = wr_fire && wr_strb[0];

  // write decode
  wire wr_high_hit  = (wr_addr == baud_pkg::ADDR_HIGH);
  wire wr_low_hit   = (wr_addr == baud_pkg::ADDR_LOW);
  wire wr_ctrl_hit  = (wr_addr == baud_pkg::ADDR_CTRL);
  wire wr_stat_hit  = (wr_addr == baud_pkg::ADDR_STATUS);
  wire wr_mask_hit  = (wr_addr == baud_pkg::ADDR_MASK);
  wire wr_opt_hit   = (wr_addr == baud_pkg::ADDR_OPTION);
  wire wr_mapped    = wr_high_hit || wr_low_hit || wr_ctrl_hit || wr_stat_hit
                      || wr_mask_hit || wr_opt_hit;
  wire wr_high      = wr_lane0 && wr_high_hit;
  wire wr_low       = wr_lane0 && wr_low_hit;
  wire wr_ctrl      = wr_lane0 && wr_ctrl_hit;
  wire wr_mask      = wr_lane0 && wr_mask_hit;
  wire wr_opt       = wr_lane0 && wr_opt_hit;

  // axi write handshake state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= baud_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_addr_q <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      aw_held_q <= wr_fire ? 1'b0 : aw_have;
      w_held_q  <= wr_fire ? 1'b0 : w_have;
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_mapped ? baud_pkg::RESP_OKAY : baud_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // read channel: one read at a time, answer one cycle after address
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire rd_take     = s_axi_arvalid && s_axi_arready;
  wire rd_high_hit = (s_axi_araddr == baud_pkg::ADDR_HIGH);
  wire rd_low_hit  = (s_axi_araddr == baud_pkg::ADDR_LOW);
  wire rd_ctrl_hit = (s_axi_araddr == baud_pkg::ADDR_CTRL);
  wire rd_stat_hit = (s_axi_araddr == baud_pkg::ADDR_STATUS);
  wire rd_mask_hit = (s_axi_araddr == baud_pkg::ADDR_MASK);
  wire rd_opt_hit  = (s_axi_araddr == baud_pkg::ADDR_OPTION);
  wire rd_mapped   = rd_high_hit || rd_low_hit || rd_ctrl_hit || rd_stat_hit
                     || rd_mask_hit || rd_opt_hit;
  wire rd_status   = rd_take && rd_stat_hit;

  // read mux; bits above a register's width read zero
  wire [7:0] rd_byte = rd_high_hit ? high_q :
                       rd_low_hit  ? low_q :
                       rd_ctrl_hit ? {6'h00, ctrl_q} :
                       rd_stat_hit ? {6'h00, status_q} :
                       rd_mask_hit ? {6'h00, mask_q} :
                       rd_opt_hit  ? {7'h00, pos_sel_q} : 8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= baud_pkg::RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h000000, rd_byte};
      rresp_q  <= rd_mapped ? baud_pkg::RESP_OKAY : baud_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // high register: enables and buffered divisor half; bit 5 is not stored
  wire [7:0] high_wr_val = {wr_data[baud_pkg::BRK_IE_BIT],
                            wr_data[baud_pkg::EDGE_IE_BIT],
                            1'b0,
                            wr_data[baud_pkg::HIGH_MSB:0]};

  // working divisor only moves on a low write, so a half-written pair is never used
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      high_q      <= {3'h0, baud_pkg::HIGH_RESET};
      high_work_q <= baud_pkg::HIGH_RESET;
      low_q       <= baud_pkg::LOW_RESET;
      ctrl_q      <= 2'h0;
      started_q   <= 1'b0;
      mask_q      <= 2'h0;
      pos_sel_q   <= 1'b0;
    end
    else
    begin
      if (wr_high)
        high_q <= high_wr_val;
      if (wr_low)
      begin
        low_q       <= wr_data[7:0];
        high_work_q <= wr_high ? high_wr_val[4:0] : high_q[4:0];
      end
      if (wr_ctrl)
        ctrl_q <= wr_data[1:0];
      if (wr_ctrl && (wr_data[baud_pkg::RX_EN_BIT] || wr_data[baud_pkg::TX_EN_BIT]))
        started_q <= 1'b1;
      if (wr_mask)
        mask_q <= wr_data[1:0];
      if (wr_opt)
        pos_sel_q <= wr_data[0];
    end
  end

  // generator runs only after first enable and with a nonzero divisor
  assign baud_divisor = {high_work_q, low_q};
  wire gen_run = started_q && (baud_divisor != 13'h0000);
  logic raw_tick;

  baud_counter u_counter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (gen_run),
    .divisor (baud_divisor),
    .tick    (raw_tick)
  );

  // sixteen oversampling ticks form one bit time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sub_q      <= 4'h0;
      bit_tick_q <= 1'b0;
    end
    else
    begin
      if (!gen_run)
        sub_q <= 4'h0;
      else if (raw_tick)
        sub_q <= sub_q + 4'h1;
      bit_tick_q <= gen_run && raw_tick && (sub_q == baud_pkg::TICK_LAST);
    end
  end
  assign oversample_tick = raw_tick;
  assign bit_tick        = bit_tick_q;

  // sticky flags: an event in the clearing read cycle survives
  wire [1:0] events = {rx_edge_event, break_event};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_q <= 2'h0;
    else
      status_q <= (rd_status ? 2'h0 : status_q) | events;
  end

  // break request follows its enable bit, edge request likewise, plus the mask
  wire brk_req  = high_q[baud_pkg::BRK_IE_BIT] && status_q[baud_pkg::ST_BRK_BIT];
  wire edge_req = high_q[baud_pkg::EDGE_IE_BIT] && status_q[baud_pkg::ST_EDGE_BIT];
  assign irq = (brk_req && mask_q[baud_pkg::ST_BRK_BIT])
               || (edge_req && mask_q[baud_pkg::ST_EDGE_BIT]);

  // receive pins come from outside and pass two flops before the mux
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      f1_sync_q <= 2'h3;
      e7_sync_q <= 2'h3;
    end
    else
    begin
      f1_sync_q <= {f1_sync_q[0], port_f1_in};
      e7_sync_q <= {e7_sync_q[0], port_e7_in};
    end
  end

  // pin routing: unselected port stays undriven
  assign second_channel_rx_pin = pos_sel_q ? e7_sync_q[1] : f1_sync_q[1];
  assign port_f0_out = second_channel_tx_pin;
  assign port_e6_out = second_channel_tx_pin;
  assign port_f0_oe  = !pos_sel_q;
  assign port_e6_oe  = pos_sel_q;
endmodule : baud_rate_gen

// File: test/baud_rate_gen_props.sv
// checker for the baud rate generator, watching only its ports
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
module baud_rate_gen_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // events, generator, pins, interrupt
  input wire logic        break_event,
  input wire logic        rx_edge_event,
  input wire logic        oversample_tick,
  input wire logic        bit_tick,
  input wire logic [12:0] baud_divisor,
  input wire logic        second_channel_tx_pin,
  input wire logic        port_f0_out,
  input wire logic        port_f0_oe,
  input wire logic        port_e6_oe,
  input wire logic        irq
);
  logic [13:0] gap_q;
  logic [4:0]  os_q;
  logic        seen_q, chg_q, bseen_q, started_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles since the last tick, ticks since the last bit, and a loose start flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {gap_q, os_q, seen_q, chg_q, bseen_q, started_q} <= '0;
    end
    else
    begin
      gap_q     <= oversample_tick ? 14'h0001 : gap_q + 14'h0001;
      seen_q    <= seen_q | oversample_tick;
      chg_q     <= (chg_q & !oversample_tick) | $changed(baud_divisor);
      os_q      <= bit_tick ? 5'(oversample_tick) : os_q + 5'(oversample_tick);
      bseen_q   <= (bseen_q | bit_tick) & (baud_divisor != 13'h0000);
      started_q <= started_q | (s_axi_wvalid & s_axi_wready & |s_axi_wdata[1:0]);
    end
  end

  AST_ZERO_STOP: assert property
    (baud_divisor == 13'h0000 && $past(baud_divisor) == 13'h0000 |-> !oversample_tick)
    else $error("tick while divisor is zero");
  AST_TICK_GAP: assert property (
    oversample_tick && seen_q && !chg_q && $stable(baud_divisor)
    |-> gap_q == {1'b0, baud_divisor}) else $error("tick spacing differs from divisor");
  AST_BIT_AFTER_TICK: assert property (bit_tick |-> $past(oversample_tick))
    else $error("bit tick without a preceding oversample tick");
  AST_BIT_SPACING: assert property (bit_tick && bseen_q |-> os_q == 5'h10)
    else $error("bit tick not every sixteenth oversample tick");
  AST_DIV_LOAD: assert property ($changed(baud_divisor) |-> $rose(s_axi_bvalid))
    else $error("working divisor changed outside a register write");
  AST_IDLE_START: assert property (oversample_tick |-> started_q)
    else $error("generator ran before any enable write");
  AST_IRQ_CAUSE: assert property ($rose(irq) |->
    $past(break_event || rx_edge_event || s_axi_wvalid && s_axi_wready))
    else $error("interrupt rose without event or write");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  AST_PIN_ROUTE: assert property
    (port_f0_oe != port_e6_oe && port_f0_out == second_channel_tx_pin)
    else $error("transmit pin routing wrong");
endmodule : baud_rate_gen_props

bind baud_rate_gen baud_rate_gen_props chk (.aclk, .aresetn, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .break_event,
  .rx_edge_event, .oversample_tick, .bit_tick, .baud_divisor, .second_channel_tx_pin,
  .port_f0_out, .port_f0_oe, .port_e6_oe, .irq);

// File: test/serial_link_model.sv
// remote serial device driving the receive line of channel two
// assumes bit_tick marks its bit times and use_e follows the pin position
`timescale 1ns/1ps
module serial_link_model (
  // clock and bit timing
  input  wire logic aclk,
  input  wire logic bit_tick,
  input  wire logic use_e,
  // receive lines toward the device
  output logic      line_f,
  output logic      line_e,
  output logic      drive
);
  logic [7:0] pat_q  = 8'hA5;
  logic       junk_q = 1'b0;

  // new data bit each bit time; the unused pin toggles since nobody drives it
  always_ff @(posedge aclk)
  begin
    junk_q <= ~junk_q;
    if (bit_tick)
      pat_q <= {pat_q[6:0], pat_q[7]};
  end

  // only the selected position carries the pattern
  assign drive  = pat_q[7];
  assign line_f = use_e ? junk_q : drive;
  assign line_e = use_e ? drive : junk_q;
endmodule : serial_link_model

// File: test/sci_baud_rate_generator_bench.sv
// self-checking bench for the baud rate generator block
// assumes the design package is compiled first and the checker is bound
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module sci_baud_rate_generator_bench;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, brk_ev, edge_ev, tx_pin;
  logic awready, wready, bvalid, arready, rvalid, os_tick, bit_tk, rx_pin, irq;
  logic f0_out, f0_oe, e6_out, e6_oe, line_f, line_e, drive;
  logic [7:0]  awaddr, araddr, lo;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [12:0] div;
  logic [7:0]  cfg_h [5] = '{8'hC0, 8'h00, 8'hC0, 8'h80, 8'h40};
  logic [7:0]  cfg_m [5] = '{8'h03, 8'h03, 8'h00, 8'h03, 8'h01};
  logic [31:0] rng = 32'h07C6B4F5;
  int mismatches = 0, n_checks = 0, cyc = 0, n, i;
  localparam logic [1:0] OK = baud_pkg::RESP_OKAY;

  // free-running bus clock
  initial forever #5 aclk = ~aclk;

  baud_rate_gen DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .break_event(brk_ev), .rx_edge_event(edge_ev),
    .oversample_tick(os_tick), .bit_tick(bit_tk), .baud_divisor(div),
    .second_channel_tx_pin(tx_pin), .second_channel_rx_pin(rx_pin), .port_f1_in(line_f),
    .port_e7_in(line_e), .port_f0_out(f0_out), .port_f0_oe(f0_oe), .port_e6_out(e6_out),
    .port_e6_oe(e6_oe), .irq(irq));
  serial_link_model far (.aclk(aclk), .bit_tick(bit_tk), .use_e(e6_oe), .line_f(line_f),
    .line_e(line_e), .drive(drive));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  // expected clocks between ticks: per times the combined divisor
  function automatic int exp_gap(input logic [7:0] hi, input logic [7:0] lo_v, input int per);
    return per * int'({hi[4:0], lo_v});
  endfunction : exp_gap
  function automatic logic exp_irq(input logic [7:0] h, input logic [7:0] m);
    return (h[7] & m[0]) | (h[6] & m[1]);
  endfunction : exp_irq

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // address and data offered together, each dropped at its own acceptance
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      ad = ad | (awvalid & awready);
      wd = wd | (wvalid & wready);
      awvalid <= !ad;
      wvalid <= !wd;
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", OK, bresp)
  endtask : wr
  // rready raised one cycle late so the slave must hold its answer
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    `CHK("rdata", {24'h000000, ex}, rdata)
    `CHK("rresp", er, rresp)
  endtask : rd
  task automatic gap(input logic bsel, output int c);
    c = 0;
    do @(posedge aclk); while (!(bsel ? bit_tk : os_tick));
    do
    begin
      @(posedge aclk);
      c++;
    end while (!(bsel ? bit_tk : os_tick));
  endtask : gap
  task automatic idle(output int c);
    c = 0;
    repeat (64)
    begin
      @(posedge aclk);
      c += int'(os_tick);
    end
  endtask : idle
  task automatic pulse();
    brk_ev <= 1'b1;
    edge_ev <= 1'b1;
    @(posedge aclk);
    brk_ev <= 1'b0;
    edge_ev <= 1'b0;
    @(posedge aclk);
  endtask : pulse

  // a hang is cut short well past the longest expected run
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, brk_ev, edge_ev, tx_pin} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(baud_pkg::ADDR_HIGH, {3'h0, baud_pkg::HIGH_RESET}, OK);
    rd(baud_pkg::ADDR_LOW, baud_pkg::LOW_RESET, OK);
    rd(8'h40, 8'h00, baud_pkg::RESP_SLVERR);
    wr(baud_pkg::ADDR_CTRL, 8'h00);
    idle(n);
    `CHK("ticks before start", 0, n)
    wr(baud_pkg::ADDR_HIGH, 8'hFF);
    rd(baud_pkg::ADDR_HIGH, 8'hDF, OK);
    `CHK("divisor held", {5'h00, baud_pkg::LOW_RESET}, div)
    lo = 8'(xs());
    wr(baud_pkg::ADDR_LOW, lo);
    `CHK("divisor loaded", {5'h1F, lo}, div)
    wr(baud_pkg::ADDR_CTRL, 8'h02);
    gap(1'b0, n);
    `CHK("large tick gap", exp_gap(8'h1F, lo, 1), n)
    for (i = 0; i < 5; i++)
    begin
      lo = (i == 0) ? 8'h01 : 8'(xs() % 15 + 1);
      wr(baud_pkg::ADDR_HIGH, 8'h00);
      wr(baud_pkg::ADDR_LOW, lo);
      gap(1'b1, n);
      gap(1'b1, n);
      `CHK("bit gap", exp_gap(8'h00, lo, baud_pkg::OVERSAMPLE), n)
    end
    wr(baud_pkg::ADDR_LOW, 8'h00);
    repeat (2) @(posedge aclk);
    idle(n);
    `CHK("ticks at zero divisor", 0, n)
    for (i = 0; i < 5; i++)
    begin
      wr(baud_pkg::ADDR_HIGH, cfg_h[i]);
      wr(baud_pkg::ADDR_MASK, cfg_m[i]);
      pulse();
      `CHK("irq raised", exp_irq(cfg_h[i], cfg_m[i]), irq)
      rd(baud_pkg::ADDR_STATUS, 8'h03, OK);
      `CHK("irq cleared", 1'b0, irq)
    end
    // events landing on the clearing read's edge must survive the clear
    fork
      rd(baud_pkg::ADDR_STATUS, 8'h00, OK);
      pulse();
    join
    rd(baud_pkg::ADDR_STATUS, 8'h03, OK);
    wr(baud_pkg::ADDR_LOW, 8'h03);
    for (i = 0; i < 2; i++)
    begin
      wr(baud_pkg::ADDR_OPTION, 8'(i));
      tx_pin <= 1'(xs());
      gap(1'b1, n);
      repeat (5) @(posedge aclk);
      `CHK("f enable", i == 0, f0_oe)
      `CHK("e enable", i == 1, e6_oe)
      `CHK("tx out", tx_pin, i ? e6_out : f0_out)
      `CHK("rx in", drive, rx_pin)
    end
    give_verdict();
  end
endmodule : sci_baud_rate_generator_bench
